// ---- shared/gpb_pkg.sv ----
// Purpose: Constants, register map and carrier types of the port B GPIO block.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes: Register offsets are chosen here; rules of the port follow.
package gpb_pkg;

   // Bus and port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PORT_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION_BITS = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_PULLUP_CONTROL = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN_CONTROL = 12'h010;

   // Reset values
   localparam logic [PORT_W-1:0] RST_OUTPUT_LATCH = 8'h00;
   localparam logic [PORT_W-1:0] RST_DIRECTION_BITS = 8'h00;
   localparam logic [PORT_W-1:0] RST_PULLUP_CONTROL = 8'h00;
   localparam logic [PORT_W-1:0] RST_OPEN_DRAIN_CONTROL = 8'h00;
   localparam logic [PORT_W-1:0] RST_PAD_OE_N = 8'hFF;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

   // Pin groups: which timer channel shares each pin
   localparam int CH5_LOW_BIT = 6;
   localparam int CH4_LOW_BIT = 4;
   localparam int MC_COUNTER_BIT = 0;
   localparam logic [1:0] TMR_CH3 = 2'h0;
   localparam logic [1:0] TMR_CH4 = 2'h1;
   localparam logic [1:0] TMR_CH5 = 2'h2;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
      logic [3:0] pstrb;
   } gpb_apb_req_s;

   // APB answer from this slave
   typedef struct packed {
      logic pready;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
   } gpb_apb_rsp_s;

   // Selections coming from the timer and motor-control units
   typedef struct packed {
      logic [PORT_W-1:0] mc_enable;
      logic [PORT_W-1:0] mc_output;
      logic [PORT_W-1:0] tmr_out_en;
      logic [PORT_W-1:0] tmr_out_val;
   } gpb_sel_s;

   // Per-pin pad cell controls
   typedef struct packed {
      logic [PORT_W-1:0] drive;
      logic [PORT_W-1:0] oe_n;
      logic [PORT_W-1:0] open_drain;
      logic [PORT_W-1:0] pullup_en;
   } gpb_pad_s;

endpackage

// ---- src/gpb_sync.sv ----
// Purpose: Two-flop synchroniser for the asynchronous pin levels.
// Assumes: Stage one is read only by stage two.
// Notes: Frozen while CE is low.
`timescale 1ns/10ps
module gpb_sync #(
   parameter int W = 8
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [W-1:0] ASYNC_IN,
   output logic [W-1:0] SYNC_OUT
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } gpb_sync_state_s;

   gpb_sync_state_s st;
   gpb_sync_state_s next_st;

   // Shift the level through both stages
   always_comb begin
      next_st = st;
      if (CE) begin
         next_st.meta = ASYNC_IN;
         next_st.stable = st.meta;
      end
   end

   // Register the synchroniser state
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign SYNC_OUT = st.stable;

endmodule // gpb_sync

// ---- src/gpb_pin_mux.sv ----
// Purpose: Per-pin function select between GPIO, timer and motor control.
// Assumes: Pure combinational; the caller registers the results.
// Notes: Bit 0 with motor control enabled is an input only.
`timescale 1ns/10ps
module gpb_pin_mux
   import gpb_pkg::*;
(
   input gpb_pkg::gpb_sel_s SEL,
   input wire logic [gpb_pkg::PORT_W-1:0] DIRECTION,
   input wire logic [gpb_pkg::PORT_W-1:0] LATCH,
   input wire logic [gpb_pkg::PORT_W-1:0] PULLUP_CTL,
   input wire logic [gpb_pkg::PORT_W-1:0] OPEN_DRAIN_CTL,
   input wire logic [gpb_pkg::PORT_W-1:0] PIN_LEVEL,
   output gpb_pkg::gpb_pad_s PAD,
   output logic [gpb_pkg::PORT_W-1:0] CAPTURE,
   output logic MC_COUNT
);

   // Choose the function, value and pad mode of every pin
   always_comb begin
      logic drive_en;
      logic value;
      PAD = '0;
      CAPTURE = '0;
      drive_en = 1'b0;
      value = 1'b0;
      for (int i = 0; i < PORT_W; i++) begin
         drive_en = 1'b0;
         value = 1'b0;
         if (SEL.mc_enable[i]) begin
            drive_en = (i != MC_COUNTER_BIT);
            value = SEL.mc_output[i];
         end else if (SEL.tmr_out_en[i]) begin
            drive_en = 1'b1;
            value = SEL.tmr_out_val[i];
         end else begin
            drive_en = DIRECTION[i];
            value = LATCH[i];
            CAPTURE[i] = PIN_LEVEL[i];
         end
         PAD.open_drain[i] = drive_en & OPEN_DRAIN_CTL[i];
         // Open drain drives low only, push-pull drives both levels
         PAD.drive[i] = OPEN_DRAIN_CTL[i] ? 1'b0 : value;
         PAD.oe_n[i] = ~(drive_en & (~OPEN_DRAIN_CTL[i] | ~value));
         PAD.pullup_en[i] = ~drive_en & PULLUP_CTL[i];
      end
      MC_COUNT = SEL.mc_enable[MC_COUNTER_BIT] & PIN_LEVEL[MC_COUNTER_BIT];
   end

endmodule // gpb_pin_mux

// ---- src/gpb_port.sv ----
// Purpose: Port B GPIO with APB registers and shared-pin multiplexer.
// Assumes: Pin levels asynchronous; timer and motor-control selects on CLK.
// Notes: Zero-wait APB; pad controls and read data come from flip-flops.
`timescale 1ns/10ps
module gpb_port
   import gpb_pkg::*;
#(
   parameter int PORT_BITS = gpb_pkg::PORT_W
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input gpb_pkg::gpb_apb_req_s APB_REQ,
   output gpb_pkg::gpb_apb_rsp_s APB_RSP,
   input gpb_pkg::gpb_sel_s PIN_SEL,
   input wire logic [gpb_pkg::PORT_W-1:0] PIN_IN,
   output gpb_pkg::gpb_pad_s PAD,
   output logic [gpb_pkg::PORT_W-1:0] TMR_CAPTURE_IN,
   output logic MC_COUNTER_IN
);

   import gpb_pkg::*;

   // Pin grouping is fixed to eight pins
   if (PORT_BITS != PORT_W) begin : g_width_check
      $error("gpb_port supports only an 8-pin port");
   end

   // Whole state of the port
   typedef struct packed {
      logic [PORT_W-1:0] output_latch;
      logic [PORT_W-1:0] direction_bits;
      logic [PORT_W-1:0] pullup_control;
      logic [PORT_W-1:0] open_drain_control;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
      gpb_pad_s pad;
      logic [PORT_W-1:0] capture;
      logic mc_count;
   } gpb_state_s;

   // Register selected by an address
   typedef enum logic [2:0] {
      REG_NONE = 3'h0,
      REG_LATCH = 3'h1,
      REG_DIRECTION = 3'h3,
      REG_PIN_STATE = 3'h2,
      REG_PULLUP = 3'h6,
      REG_OPEN_DRAIN = 3'h7
   } gpb_reg_e;

   gpb_state_s st;
   gpb_state_s next_st;
   logic [PORT_W-1:0] pin_level;
   logic [PORT_W-1:0] pin_state_value;
   gpb_pad_s mux_pad;
   logic [PORT_W-1:0] mux_capture;
   logic mux_mc_count;
   logic setup_phase;
   logic access_phase;
   gpb_reg_e rd_reg;
   gpb_reg_e wr_reg;

   // Decode an APB address into a register, shared by read and write paths
   function automatic gpb_reg_e decode_addr(input logic [ADDR_W-1:0] addr);
      gpb_reg_e r;
      r = REG_NONE;
      if (addr == OFS_OUTPUT_LATCH) begin
         r = REG_LATCH;
      end else if (addr == OFS_DIRECTION_BITS) begin
         r = REG_DIRECTION;
      end else if (addr == OFS_PIN_STATE) begin
         r = REG_PIN_STATE;
      end else if (addr == OFS_PULLUP_CONTROL) begin
         r = REG_PULLUP;
      end else if (addr == OFS_OPEN_DRAIN_CONTROL) begin
         r = REG_OPEN_DRAIN;
      end
      return r;
   endfunction

   // Place an 8-bit register in the low byte of a bus word
   function automatic logic [DATA_W-1:0] to_word(input logic [PORT_W-1:0] v);
      return {{(DATA_W - PORT_W){1'b0}}, v};
   endfunction

   // Bring the pin levels into the clock domain
   gpb_sync #(
      .W(PORT_W)
   ) u_sync (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .CE(CE),
      .ASYNC_IN(PIN_IN),
      .SYNC_OUT(pin_level)
   );

   // Function select for every pin
   gpb_pin_mux u_mux (
      .SEL(PIN_SEL),
      .DIRECTION(st.direction_bits),
      .LATCH(st.output_latch),
      .PULLUP_CTL(st.pullup_control),
      .OPEN_DRAIN_CTL(st.open_drain_control),
      .PIN_LEVEL(pin_level),
      .PAD(mux_pad),
      .CAPTURE(mux_capture),
      .MC_COUNT(mux_mc_count)
   );

   // Output bits show the latch, input bits the pin
   assign pin_state_value = (st.direction_bits & st.output_latch)
      | (~st.direction_bits & pin_level);

   // Bus phases
   assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
   assign access_phase = APB_REQ.psel & APB_REQ.penable;
   assign rd_reg = decode_addr(APB_REQ.paddr);
   assign wr_reg = rd_reg;

   // Next state: register writes, read data and pad controls
   always_comb begin
      next_st = st;
      if (CE) begin
         // Read data and error flag are prepared in the setup cycle
         if (setup_phase) begin
            next_st.pslverr = (rd_reg == REG_NONE);
            if (APB_REQ.pwrite) begin
               next_st.prdata = RDATA_ZERO;
            end else begin
               case (rd_reg)
                  REG_LATCH: begin
                     next_st.prdata = to_word(st.output_latch);
                  end
                  REG_DIRECTION: begin
                     next_st.prdata = RDATA_ZERO;
                  end
                  REG_PIN_STATE: begin
                     next_st.prdata = to_word(pin_state_value);
                  end
                  REG_PULLUP: begin
                     next_st.prdata = to_word(st.pullup_control);
                  end
                  REG_OPEN_DRAIN: begin
                     next_st.prdata = to_word(st.open_drain_control);
                  end
                  default: begin
                     next_st.prdata = RDATA_ZERO;
                  end
               endcase
            end
         end
         // Writes take effect at the completing access edge
         if (access_phase && APB_REQ.pwrite && APB_REQ.pstrb[0]) begin
            case (wr_reg)
               REG_LATCH: begin
                  next_st.output_latch = APB_REQ.pwdata[PORT_W-1:0];
               end
               REG_DIRECTION: begin
                  next_st.direction_bits = APB_REQ.pwdata[PORT_W-1:0];
               end
               REG_PULLUP: begin
                  next_st.pullup_control = APB_REQ.pwdata[PORT_W-1:0];
               end
               REG_OPEN_DRAIN: begin
                  next_st.open_drain_control = APB_REQ.pwdata[PORT_W-1:0];
               end
               default: begin
                  next_st.output_latch = st.output_latch;
               end
            endcase
         end
         // Pad controls follow the mux selection every cycle that CE is high
         next_st.pad = mux_pad;
         next_st.capture = mux_capture;
         next_st.mc_count = mux_mc_count;
      end
   end

   // Register the whole state
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st.output_latch <= RST_OUTPUT_LATCH;
         st.direction_bits <= RST_DIRECTION_BITS;
         st.pullup_control <= RST_PULLUP_CONTROL;
         st.open_drain_control <= RST_OPEN_DRAIN_CONTROL;
         st.prdata <= RDATA_ZERO;
         st.pslverr <= 1'b0;
         st.pad.drive <= '0;
         st.pad.oe_n <= RST_PAD_OE_N;
         st.pad.open_drain <= '0;
         st.pad.pullup_en <= '0;
         st.capture <= '0;
         st.mc_count <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Zero-wait answer; ready is held low only while frozen
   always_comb begin
      APB_RSP.pready = CE;
      APB_RSP.prdata = st.prdata;
      APB_RSP.pslverr = st.pslverr & access_phase;
   end

   // Registered outputs toward pads and the timer units
   assign PAD = st.pad;
   assign TMR_CAPTURE_IN = st.capture;
   assign MC_COUNTER_IN = st.mc_count;

endmodule // gpb_port

// ---- test/gpb_port_asserts.sv ----
// Purpose: Concurrent checks on pad, capture and counter outputs of the port.
// Assumes: Bound to gpb_port; sees only its ports.
// Notes: Pad outputs follow selections one enabled edge later.
`timescale 1ns/10ps
module gpb_port_asserts
   import gpb_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input gpb_pkg::gpb_apb_req_s APB_REQ,
   input gpb_pkg::gpb_apb_rsp_s APB_RSP,
   input gpb_pkg::gpb_sel_s PIN_SEL,
   input wire logic [gpb_pkg::PORT_W-1:0] PIN_IN,
   input gpb_pkg::gpb_pad_s PAD,
   input wire logic [gpb_pkg::PORT_W-1:0] TMR_CAPTURE_IN,
   input wire logic MC_COUNTER_IN
);
   // One clock domain
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // Pad and select relations
   AST_RESET_PADS: assert property (disable iff (1'b0) SYS_RST |=> PAD.oe_n == RST_PAD_OE_N
      && PAD.pullup_en == 8'h00 && !MC_COUNTER_IN) else $error("pads not reset");
   AST_OD_PULLUP: assert property ((PAD.pullup_en & PAD.open_drain) == 8'h00)
      else $error("pull-up on open-drain pin");
   AST_OD_DRIVE: assert property ((PAD.drive & PAD.open_drain) == 8'h00)
      else $error("open-drain pin driven high");
   AST_MC_LOW: assert property (CE |=> ((PAD.oe_n | PAD.drive)
      & $past(PIN_SEL.mc_enable & ~PIN_SEL.mc_output & 8'hFE)) == 8'h00)
      else $error("motor-control low not driven");
   AST_TMR_LOW: assert property (CE |=> ((PAD.oe_n | PAD.drive)
      & $past(PIN_SEL.tmr_out_en & ~PIN_SEL.mc_enable & ~PIN_SEL.tmr_out_val)) == 8'h00)
      else $error("timer low not driven");
   AST_CAP_MASK: assert property (CE |=> (TMR_CAPTURE_IN
      & $past(PIN_SEL.tmr_out_en | PIN_SEL.mc_enable)) == 8'h00) else $error("capture leak");
   AST_CNT_OFF: assert property (CE && !PIN_SEL.mc_enable[0] |=> !MC_COUNTER_IN)
      else $error("counter input while disabled");
   AST_PIN0_IN: assert property (CE && PIN_SEL.mc_enable[0] |=> PAD.oe_n[0])
      else $error("counter pin driven");
   AST_CE_HOLD: assert property (!CE |=> $stable(PAD)) else $error("pads moved");
   // Main scenarios
   AST_COV_WRITE: cover property (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite
      && APB_RSP.pready);
   AST_COV_ERR: cover property (APB_REQ.psel && APB_REQ.penable && APB_RSP.pslverr);
   AST_COV_CNT: cover property (MC_COUNTER_IN);
endmodule // gpb_port_asserts

bind gpb_port gpb_port_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
   .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PIN_SEL(PIN_SEL), .PIN_IN(PIN_IN), .PAD(PAD),
   .TMR_CAPTURE_IN(TMR_CAPTURE_IN), .MC_COUNTER_IN(MC_COUNTER_IN));

// ---- test/gpb_pins_model.sv ----
// Purpose: Board side of the eight port pins.
// Assumes: Board drives only pins the block leaves released.
// Notes: A pin with no driver and no pull-up changes every cycle.
`timescale 1ns/10ps
module gpb_pins_model
   import gpb_pkg::*;
(
   input wire logic CLK,
   input gpb_pkg::gpb_pad_s PAD,
   input wire logic [gpb_pkg::PORT_W-1:0] BOARD_VAL,
   input wire logic [gpb_pkg::PORT_W-1:0] BOARD_EN,
   output logic [gpb_pkg::PORT_W-1:0] PIN_IN
);
   logic [PORT_W-1:0] flt = 8'h00;
   // Floating level keeps changing
   always @(posedge CLK) flt <= ~flt;
   // Wire level from pad, board and pull-up
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         if (!PAD.oe_n[i]) PIN_IN[i] = PAD.drive[i];
         else if (BOARD_EN[i]) PIN_IN[i] = BOARD_VAL[i];
         else if (PAD.pullup_en[i]) PIN_IN[i] = 1'b1;
         else PIN_IN[i] = flt[i];
      end
   end
endmodule // gpb_pins_model

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the port B GPIO block.
// Assumes: Zero-wait APB slave; board keeps off pins the block drives.
// Notes: Every bus wait is bounded.
`timescale 1ns/10ps
module testbench;
   import gpb_pkg::*;
   logic clk, sys_rst, ce, mc_cnt, err;
   gpb_apb_req_s req;
   gpb_apb_rsp_s rsp;
   gpb_sel_s sel;
   gpb_pad_s pad;
   logic [7:0] pin_in, cap, brd_val, brd_en;
   logic [31:0] rd;
   int n_mismatch, cmp_count;
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   gpb_port dut (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .APB_REQ(req), .APB_RSP(rsp),
      .PIN_SEL(sel), .PIN_IN(pin_in), .PAD(pad), .TMR_CAPTURE_IN(cap), .MC_COUNTER_IN(mc_cnt));
   gpb_pins_model board (.CLK(clk), .PAD(pad), .BOARD_VAL(brd_val), .BOARD_EN(brd_en),
      .PIN_IN(pin_in));
   // Verdict and end of run
   task automatic print_verdict();
      $display("cmp_count=%0d n_mismatch=%0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 4'hF);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, 4'hF);
      chk(rd, {24'h0, e});
   endtask
   // Pad controls packed as open-drain, enable, drive, pull-up
   task automatic chk_pad(input logic [31:0] e);
      chk({pad.open_drain, pad.oe_n, pad.drive, pad.pullup_en}, e);
   endtask
   task automatic t_reset();
      rdc(OFS_OUTPUT_LATCH, 8'h00);
      rdc(OFS_PULLUP_CONTROL, 8'h00);
      rdc(OFS_OPEN_DRAIN_CONTROL, 8'h00);
      chk_pad(32'h00FF0000);
      $display("reset test done");
   endtask
   task automatic t_gpio();
      wr(OFS_DIRECTION_BITS, 8'h0F);
      wr(OFS_OUTPUT_LATCH, 8'hA5);
      brd_en <= 8'hF0;
      brd_val <= 8'h3C;
      repeat (4) @(posedge clk);
      rdc(OFS_PIN_STATE, 8'h35);
      rdc(OFS_DIRECTION_BITS, 8'h00);
      chk_pad(32'h00F0A500);
      $display("gpio test done");
   endtask
   task automatic t_refuse();
      wr(OFS_PIN_STATE, 8'hFF);
      chk({31'h0, err}, 32'h0);
      rdc(OFS_PIN_STATE, 8'h35);
      apb(1'b1, OFS_OUTPUT_LATCH, 32'hFF, 4'h0);
      rdc(OFS_OUTPUT_LATCH, 8'hA5);
      apb(1'b0, 12'h014, 32'h0, 4'hF);
      chk({rd[30:0], err}, 32'h1);
      $display("refusal test done");
   endtask
   task automatic t_pull_od();
      wr(OFS_PULLUP_CONTROL, 8'hFF);
      wr(OFS_OPEN_DRAIN_CONTROL, 8'h03);
      repeat (2) @(posedge clk);
      chk_pad(32'h03F1A4F0);
      $display("pull-up test done");
   endtask
   task automatic t_mux();
      wr(OFS_DIRECTION_BITS, 8'h0E);
      brd_en <= 8'h40;
      brd_val <= 8'h40;
      sel <= '{mc_enable: 8'h81, mc_output: 8'h80, tmr_out_en: 8'h38, tmr_out_val: 8'h18};
      repeat (6) @(posedge clk);
      chk_pad(32'h02419C41);
      chk({24'h0, cap}, 32'h44);
      chk({31'h0, mc_cnt}, 32'h1);
      rdc(OFS_PIN_STATE, 8'hD5);
      $display("mux test done");
   endtask
   // Clock enable low freezes the pads, then they follow the cleared selects
   task automatic t_freeze();
      ce <= 1'b0;
      sel <= '0;
      repeat (3) @(posedge clk);
      chk_pad(32'h02419C41);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      chk_pad(32'h02F1A4F1);
      chk({31'h0, mc_cnt}, 32'h0);
      $display("freeze test done");
   endtask
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      req = '0;
      sel = '0;
      brd_val = 8'h00;
      brd_en = 8'h00;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_gpio();
      t_refuse();
      t_pull_od();
      t_mux();
      t_freeze();
      print_verdict();
   end
endmodule // testbench
